// ===== rtl/fbg_guard.sv
/*
 Bus guard for one channel: checks master id and direction against the
 protection word. Assumes a registered protection word from the top.
*/
`timescale 1ns/1ns
module fbg_guard
(
	input  wire logic [31:0] prot,
	input  wire logic [2:0]  master_id,
	input  wire logic        is_write,
	input  wire logic        hit,
	output logic             blocked
);
	import fbg_pkg::*;
	logic allowed;

	// Master in the allow field, or global permission for direction
	assign allowed = prot[FBG_PROT_MASTER_LO + 32'(master_id)]
		|| (is_write ? prot[FBG_PROT_WG_BIT] : prot[FBG_PROT_RG_BIT]);
	assign blocked = hit && !allowed;
endmodule // fbg_guard

// ===== rtl/fbg_pkg.sv
/*
 Shared constants for the flash boot guard: register offsets, guard
 protection layout, reset values, error bits and sequencer clock ratios.
 Assumes a 32-bit word register port with byte enables.
*/
package fbg_pkg;
	localparam int unsigned FBG_AW = 32;
	localparam int unsigned FBG_DW = 32;
	// Guard group number selects the error register base
	localparam logic [7:0]  FBG_GUARD_GROUP    = 8'h06;
	localparam logic [31:0] FBG_PROT_BASE      = 32'hFFF90000;
	localparam logic [31:0] FBG_ADDR_PROT5     = 32'hFFF90014;
	localparam logic [31:0] FBG_ADDR_PROT6     = 32'hFFF90018;
	localparam logic [31:0] FBG_PROT_RESET     = 32'h066FFFF7;
	// Error report block: base = err root + group * stride
	localparam logic [31:0] FBG_ERR_ROOT       = 32'hFFC4C000;
	localparam logic [31:0] FBG_ERR_STRIDE     = 32'h00000100;
	localparam logic [31:0] FBG_ERR_BASE       = FBG_ERR_ROOT
		+ {24'h000000, FBG_GUARD_GROUP} * FBG_ERR_STRIDE;
	localparam logic [31:0] FBG_ERR_STAT_OFS   = 32'h00000000;
	localparam logic [31:0] FBG_ERR_ADDR_OFS   = 32'h00000004;
	localparam logic [31:0] FBG_ERR_CLR_OFS    = 32'h00000008;
	// Sequencer control block
	localparam logic [31:0] FBG_SEQ_BASE       = 32'hFFA10000;
	localparam logic [31:0] FBG_REG_CMD        = 32'h00000000;
	localparam logic [31:0] FBG_REG_STATUS     = 32'h00000004;
	localparam logic [31:0] FBG_REG_IRQ_STAT   = 32'h00000008;
	localparam logic [31:0] FBG_REG_IRQ_MASK   = 32'h0000000C;
	localparam logic [31:0] FBG_REG_VECTOR     = 32'h00000010;
	localparam logic [31:0] FBG_REG_OTP        = 32'h00000014;
	localparam logic [31:0] FBG_REG_ID_BASE    = 32'h00000020;
	localparam logic [31:0] FBG_REG_ID_STATUS  = 32'h00000030;
	localparam logic [31:0] FBG_REG_CTRL_LIMIT = 32'h00000100;
	// Command codes in the command word low byte
	localparam logic [7:0]  FBG_CMD_CONFIG_VEC = 8'h40;
	localparam logic [7:0]  FBG_CMD_OTP_SET    = 8'h41;
	// Protection register fields
	localparam int unsigned FBG_PROT_WG_BIT    = 0;
	localparam int unsigned FBG_PROT_RG_BIT    = 1;
	localparam int unsigned FBG_PROT_MASTER_LO = 8;
	localparam int unsigned FBG_NUM_MASTERS    = 8;
	// Interrupt bits
	localparam int unsigned FBG_IRQ_ILGL       = 0;
	localparam int unsigned FBG_IRQ_ECC        = 1;
	localparam int unsigned FBG_IRQ_GUARD      = 2;
	localparam int unsigned FBG_IRQ_W          = 3;
	// Code flash area layout
	localparam int unsigned FBG_NUM_AREAS      = 8;
	localparam int unsigned FBG_AREA_SHIFT     = 21;
	localparam logic [31:0] FBG_VECTOR_RESET   = 32'h00000000;
	localparam logic [6:0]  FBG_ECC_ALL_ONES   = 7'h7F;
	// Sequencer clock ratios
	localparam int unsigned FBG_DIV_SLOW       = 8;
	localparam int unsigned FBG_DIV_FAST       = 4;
endpackage

// ===== rtl/fbg_seq_clk.sv
/*
 Sequencer clock enable generator: one pulse every eighth or fourth
 CPU clock. Assumes the option inputs are static in operation.
*/
`timescale 1ns/1ns
module fbg_seq_clk
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic cpu_clock_divider_option,
	input  wire logic slow_part,
	output logic      sequencer_clock
);
	import fbg_pkg::*;
	logic [2:0] cnt;
	logic [2:0] last;

	// Eighth when option set or slow part, quarter otherwise
	assign last = (cpu_clock_divider_option || slow_part) ? 3'(FBG_DIV_SLOW - 1)
		: 3'(FBG_DIV_FAST - 1);

	// Free divider; terminal count pulses the sequencer tick
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt             <= 3'h0;
			sequencer_clock <= 1'b0;
		end
		else
		begin
			cnt             <= (cnt >= last) ? 3'h0 : cnt + 3'h1;
			sequencer_clock <= (cnt >= last);
		end
	end

	// No tick can follow a tick within three cycles, whatever the ratio
	property p_div_gap;
		@(posedge clk) disable iff (!rst_b)
		sequencer_clock |=> !sequencer_clock[*3];
	endproperty
	a_div_gap : assert property (p_div_gap) else $error("Sequencer ticks too close");

	// Ratio seen at the last count decides whether the fourth cycle ticks
	property p_div_period;
		@(posedge clk) disable iff (!rst_b)
		sequencer_clock ##3 (!cpu_clock_divider_option && !slow_part) |=> sequencer_clock;
	endproperty
	a_div_period : assert property (p_div_period) else $error("Quarter divider period wrong");
endmodule // fbg_seq_clk

// ===== rtl/fbg_top.sv
/*
 Flash boot guard: guard protection registers for channels 5 and 6,
 guard error report, relocatable reset vector with OTP blocking, blank
 read ECC detection and sequencer clock.
 Assumes one register port master and a flash read port on this clock.
*/
// Functional notes
// - Config command rewrites reset vector
// - Refuse vector inside OTP area
// - Blocking holds for reserved or all-ones OTP
// - Refused vector raises illegal command flag
// - Erased unprogrammed read gives ECC exception
// - Guard group 06 channels 5 and 6
// - Per channel protection register, byte lanes
// - Error registers at group-selected base
// - Lock bit cleared by unlocked erase
// - Sequencer clock eighth or quarter
`timescale 1ns/1ns
module fbg_top
(
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic [fbg_pkg::FBG_AW-1:0] addr,
	input  wire logic [fbg_pkg::FBG_DW-1:0] wdata,
	input  wire logic [3:0]                 byte_en,
	input  wire logic                       wr,
	input  wire logic                       rd,
	input  wire logic [2:0]                 master_id,
	output logic      [fbg_pkg::FBG_DW-1:0] rdata,
	input  wire logic                       cpu_clock_divider_option,
	input  wire logic                       slow_part,
	input  wire logic                       flash_rd,
	input  wire logic [31:0]                flash_rd_data,
	input  wire logic [6:0]                 flash_rd_ecc,
	input  wire logic                       flash_ecc_err,
	input  wire logic                       lock_erase_done,
	input  wire logic                       lock_abort,
	output logic                            ecc_exception,
	output logic      [31:0]                reset_vector,
	output logic                            lock_bit,
	output logic                            sequencer_clock,
	output logic                            irq
);
	import fbg_pkg::*;
	logic [31:0]              prot5;
	logic [31:0]              prot6;
	logic [31:0]              vector;
	logic [FBG_NUM_AREAS-1:0] otp_area;
	logic [FBG_IRQ_W-1:0]     irq_stat;
	logic [FBG_IRQ_W-1:0]     irq_mask;
	logic                     illegal_command_flag;
	logic                     guard_err;
	logic [31:0]              guard_err_addr;
	logic [31:0]              id_word [4];
	logic                     id_ok;
	logic [31:0]              rel;
	logic [31:0]              err_rel;
	logic                     hit_ch5;
	logic                     hit_ch6;
	logic                     blk5;
	logic                     blk6;
	logic                     blocked;
	logic                     wr_ok;
	logic                     rd_ok;
	logic                     cmd_wr;
	logic [31:0]              next_vector;
	logic [2:0]               vec_area;
	logic                     vec_refuse;
	logic [2:0]               otp_target;
	logic [31:0]              bmask;
	logic                     ev_ilgl;
	logic                     ev_ecc;
	logic                     blank_read;
	logic [FBG_IRQ_W-1:0]     ev;
	logic [FBG_IRQ_W-1:0]     clr;

	// Channel decode: ch5 self-prog id, ch6 control and command area
	assign rel     = addr - FBG_SEQ_BASE;
	assign err_rel = addr - FBG_ERR_BASE;
	assign hit_ch5 = (addr >= FBG_SEQ_BASE) && (rel >= FBG_REG_ID_BASE)
		&& (rel <= FBG_REG_ID_STATUS);
	assign hit_ch6 = (addr >= FBG_SEQ_BASE) && (rel < FBG_REG_CTRL_LIMIT)
		&& !hit_ch5;

	fbg_guard u_guard5 (
		.prot      (prot5),
		.master_id (master_id),
		.is_write  (wr),
		.hit       (hit_ch5 && (wr || rd)),
		.blocked   (blk5)
	);

	fbg_guard u_guard6 (
		.prot      (prot6),
		.master_id (master_id),
		.is_write  (wr),
		.hit       (hit_ch6 && (wr || rd)),
		.blocked   (blk6)
	);

	fbg_seq_clk u_seq_clk (
		.clk                      (clk),
		.rst_b                    (rst_b),
		.cpu_clock_divider_option (cpu_clock_divider_option),
		.slow_part                (slow_part),
		.sequencer_clock          (sequencer_clock)
	);

	assign blocked = blk5 || blk6;
	assign wr_ok   = wr && !blocked;
	assign rd_ok   = rd && !blocked;
	assign cmd_wr  = wr_ok && hit_ch6 && (rel == FBG_REG_CMD);

	// Byte lane mask for 8/16/32 bit writes
	always_comb
	begin
		bmask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
	end

	// Protection words, one per channel, byte writable
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prot5 <= FBG_PROT_RESET;
			prot6 <= FBG_PROT_RESET;
		end
		else if (wr)
		begin
			if (addr == FBG_ADDR_PROT5)
				prot5 <= (prot5 & ~bmask) | (wdata & bmask);
			if (addr == FBG_ADDR_PROT6)
				prot6 <= (prot6 & ~bmask) | (wdata & bmask);
		end
	end

	// Vector target area; OTP marks are sticky whatever the outcome
	assign next_vector = {wdata[31:8], 8'h00};
	assign vec_area    = next_vector[FBG_AREA_SHIFT +: 3];
	assign vec_refuse  = otp_area[vec_area];
	assign otp_target  = wdata[FBG_AREA_SHIFT +: 3];

	// OTP applied marks, set even for reserved or all-ones settings
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			otp_area <= '0;
		else if (cmd_wr && wdata[7:0] == FBG_CMD_OTP_SET)
			otp_area[otp_target] <= 1'b1;
	end

	// Reset vector rewritten by config command unless area is protected
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			vector <= FBG_VECTOR_RESET;
		else if (cmd_wr && wdata[7:0] == FBG_CMD_CONFIG_VEC && !vec_refuse)
			vector <= next_vector;
	end
	assign reset_vector = vector;

	assign ev_ilgl = cmd_wr && wdata[7:0] == FBG_CMD_CONFIG_VEC && vec_refuse;

	// Illegal command flag, set wins over clear by status write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			illegal_command_flag <= 1'b0;
		else if (ev_ilgl)
			illegal_command_flag <= 1'b1;
		else if (wr_ok && hit_ch6 && rel == FBG_REG_STATUS && wdata[0])
			illegal_command_flag <= 1'b0;
	end

	// Erased cells read all ones with all-ones ECC, which fails the code
	assign blank_read = flash_rd && (&flash_rd_data) && (flash_rd_ecc == FBG_ECC_ALL_ONES);
	assign ev_ecc     = flash_rd && (flash_ecc_err || blank_read);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ecc_exception <= 1'b0;
		else
			ecc_exception <= ev_ecc;
	end

	// Lock bit stuck by aborted P/E, freed by unlocked block erase
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			lock_bit <= 1'b0;
		else if (lock_abort)
			lock_bit <= 1'b1;
		else if (lock_erase_done)
			lock_bit <= 1'b0;
	end

	// Guard error record, first blocked access address kept
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			guard_err      <= 1'b0;
			guard_err_addr <= 32'h00000000;
		end
		else if (blocked)
		begin
			guard_err <= 1'b1;
			if (!guard_err)
				guard_err_addr <= addr;
		end
		else if (wr && err_rel == FBG_ERR_CLR_OFS && wdata[0])
			guard_err <= 1'b0;
	end

	// Self-programming id words, written by software under ch5
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			id_word <= '{default: 32'h00000000};
			id_ok   <= 1'b0;
		end
		else if (wr_ok && hit_ch5 && rel < FBG_REG_ID_STATUS)
		begin
			id_word[rel[3:2]] <= wdata;
			id_ok             <= 1'b1;
		end
	end

	// Interrupt status: sticky, write one to clear, set wins
	assign ev  = {blocked, ev_ecc, ev_ilgl}; // Every blocked access flags
	assign clr = (wr_ok && hit_ch6 && rel == FBG_REG_IRQ_STAT) ? wdata[FBG_IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_stat <= '0;
			irq_mask <= '0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~clr) | ev;
			if (wr_ok && hit_ch6 && rel == FBG_REG_IRQ_MASK)
				irq_mask <= wdata[FBG_IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// Read mux, unmapped and blocked reads give zero one cycle later
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= 32'h00000000;
		else if (!rd_ok)
			rdata <= 32'h00000000;
		else if (addr == FBG_ADDR_PROT5)
			rdata <= prot5;
		else if (addr == FBG_ADDR_PROT6)
			rdata <= prot6;
		else if (err_rel == FBG_ERR_STAT_OFS)
			rdata <= {31'h0, guard_err};
		else if (err_rel == FBG_ERR_ADDR_OFS)
			rdata <= guard_err_addr;
		else if (hit_ch5 && rel == FBG_REG_ID_STATUS)
			rdata <= {31'h0, id_ok};
		else if (hit_ch5)
			rdata <= id_word[rel[3:2]];
		else if (hit_ch6 && rel == FBG_REG_STATUS)
			rdata <= {29'h0, lock_bit, sequencer_clock, illegal_command_flag};
		else if (hit_ch6 && rel == FBG_REG_IRQ_STAT)
			rdata <= {29'h0, irq_stat};
		else if (hit_ch6 && rel == FBG_REG_IRQ_MASK)
			rdata <= {29'h0, irq_mask};
		else if (hit_ch6 && rel == FBG_REG_VECTOR)
			rdata <= vector;
		else if (hit_ch6 && rel == FBG_REG_OTP)
			rdata <= {24'h0, otp_area};
		else
			rdata <= 32'h00000000;
	end

	property p_refuse;
		@(posedge clk) disable iff (!rst_b) ev_ilgl |=> $stable(vector) && illegal_command_flag;
	endproperty
	a_refuse : assert property (p_refuse) else $error("Protected vector accepted");
	property p_accept;
		@(posedge clk) disable iff (!rst_b)
		cmd_wr && wdata[7:0] == FBG_CMD_CONFIG_VEC && !vec_refuse
		|=> reset_vector == $past(next_vector);
	endproperty
	a_accept : assert property (p_accept) else $error("Vector not rewritten");
	// Any OTP command marks its area and keeps every mark set before it
	property p_otp_sticky;
		@(posedge clk) disable iff (!rst_b)
		cmd_wr && wdata[7:0] == FBG_CMD_OTP_SET
		|=> otp_area[$past(otp_target)] && ((otp_area & $past(otp_area)) == $past(otp_area));
	endproperty
	a_otp_sticky : assert property (p_otp_sticky) else $error("OTP mark lost");
	property p_ecc;
		@(posedge clk) disable iff (!rst_b) flash_rd && blank_read |=> ecc_exception;
	endproperty
	a_ecc : assert property (p_ecc) else $error("Blank read without exception");
	property p_guard;
		@(posedge clk) disable iff (!rst_b)
		blocked |=> guard_err && $stable(prot5) && $stable(prot6) && $stable(vector);
	endproperty
	a_guard : assert property (p_guard) else $error("Blocked access not recorded");
	property p_prot_rst;
		@(posedge clk) $rose(rst_b) |-> prot5 == FBG_PROT_RESET && prot6 == FBG_PROT_RESET;
	endproperty
	a_prot_rst : assert property (p_prot_rst) else $error("Protection reset value wrong");
	property p_irq;
		@(posedge clk) disable iff (!rst_b)
		ev_ilgl && irq_mask[FBG_IRQ_ILGL] |=> irq;
	endproperty
	a_irq : assert property (p_irq) else $error("Masked-in event gave no irq");
	property p_lock;
		@(posedge clk) disable iff (!rst_b) lock_erase_done && !lock_abort |=> !lock_bit;
	endproperty
	a_lock : assert property (p_lock) else $error("Lock bit not cleared");
endmodule // fbg_top

// ===== verification/fbg_cpu_model.sv
/*
 Register port master standing in for CPU software.
 Assumes the guard never stalls and read data follow one cycle later.
*/
`timescale 1ns/1ns
module fbg_cpu_model
(
	input  wire logic clk,
	output logic [31:0] addr,
	output logic [31:0] wdata,
	output logic [3:0]  byte_en,
	output logic        wr,
	output logic        rd,
	output logic [2:0]  master_id
);
	// Idle values at time zero
	initial
	begin
		addr = 32'h00000000;
		wdata = 32'h00000000;
		byte_en = 4'h0;
		wr = 1'b0;
		rd = 1'b0;
		master_id = 3'h0;
	end

	// One write cycle; bus shows inverted values once released
	// Rewrites a written place whenever called again, never runs from flash
	task automatic write_reg(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic [2:0] m);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		byte_en <= be;
		master_id <= m;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask

	// One read cycle; data are picked up by the watcher
	task automatic read_reg(input logic [31:0] a, input logic [2:0] m);
		@(posedge clk);
		addr <= a;
		master_id <= m;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
	endtask
endmodule // fbg_cpu_model

// ===== verification/tb.sv
/*
 Self-checking bench for the flash boot guard.
 Assumes the guard protection reset value opens both channels.
*/
`timescale 1ns/1ns
module tb;
	import fbg_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [31:0] addr, wdata, rdata, reset_vector, r, vec;
	logic [31:0] frd_data = 32'h00000000;
	logic [3:0]  byte_en;
	logic [2:0]  master_id;
	logic [6:0]  frd_ecc = 7'h00;
	logic        wr, rd, ecc_exc, lock_bit, seq_clk, irq;
	logic        div_opt = 1'b0, slow = 1'b0, frd = 1'b0, ecc_err = 1'b0;
	logic        lk_done = 1'b0, lk_abort = 1'b0, pend = 1'b0;
	logic [31:0] exp_q[$], msk_q[$];
	int          error_cnt = 0, tests_run = 0, n, i;
	integer      seed = 32'hA89E7125;
	localparam logic [31:0] SB = FBG_SEQ_BASE;

	always #20 clk = ~clk;

	fbg_cpu_model cpu (.clk(clk), .addr(addr), .wdata(wdata), .byte_en(byte_en),
		.wr(wr), .rd(rd), .master_id(master_id));

	fbg_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .byte_en(byte_en),
		.wr(wr), .rd(rd), .master_id(master_id), .rdata(rdata),
		.cpu_clock_divider_option(div_opt), .slow_part(slow), .flash_rd(frd),
		.flash_rd_data(frd_data), .flash_rd_ecc(frd_ecc), .flash_ecc_err(ecc_err),
		.lock_erase_done(lk_done), .lock_abort(lk_abort), .ecc_exception(ecc_exc),
		.reset_vector(reset_vector), .lock_bit(lock_bit),
		.sequencer_clock(seq_clk), .irq(irq));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Note the expected word, then read
	task automatic rd_exp(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [2:0] id);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		cpu.read_reg(a, id);
	endtask

	// Flash read pulse, exception looked at in its one cycle
	task automatic frd_chk(input logic [31:0] d, input logic [6:0] c, input logic er,
		input logic e);
		@(posedge clk);
		frd <= 1'b1;
		frd_data <= d;
		frd_ecc <= c;
		ecc_err <= er;
		@(posedge clk);
		frd <= 1'b0;
		frd_data <= ~d;
		frd_ecc <= ~c;
		ecc_err <= 1'b0;
		#1 chk("ecc_exception", {31'h0, e}, {31'h0, ecc_exc});
		@(posedge clk);
		#1 chk("ecc_exception end", 32'h0, {31'h0, ecc_exc});
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (pend)
		begin
			if (exp_q.size() == 0)
				chk("rdata unexpected", 32'h0, 32'hFFFFFFFF);
			else
			begin
				chk("rdata", exp_q[0], rdata & msk_q[0]);
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
		pend <= rd;
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd_exp(FBG_ADDR_PROT5, FBG_PROT_RESET, '1, 3'h0);
		rd_exp(FBG_ADDR_PROT6, FBG_PROT_RESET, '1, 3'h0);
		rd_exp(32'h00000100, 32'h0, '1, 3'h0);
		cpu.write_reg(SB + FBG_REG_IRQ_MASK, 32'h7, 4'hF, 3'h0);
		// Random vector in an area never made one-time
		r = $random(seed);
		vec = {8'h00, 3'h1, r[20:8], 8'h00};
		cpu.write_reg(SB, {vec[31:8], FBG_CMD_CONFIG_VEC}, 4'hF, 3'h0);
		#1 chk("reset_vector", vec, reset_vector);
		rd_exp(SB + FBG_REG_VECTOR, vec, '1, 3'h0);
		// Ordinary area, then one written with all bits at one
		for (i = 0; i < 2; i++)
		begin
			r = (i == 0) ? 32'h00600000 : 32'hFFE00000;
			cpu.write_reg(SB, {r[31:8], FBG_CMD_OTP_SET}, 4'hF, 3'h0);
			cpu.write_reg(SB, {8'h00, r[23:21], 13'h0, FBG_CMD_CONFIG_VEC}, 4'hF, 3'h0);
			#1 chk("vector refused", vec, reset_vector);
			chk("irq set", 32'h1, {31'h0, irq});
			rd_exp(SB + FBG_REG_STATUS, 32'h1, 32'h1, 3'h0);
			rd_exp(SB + FBG_REG_IRQ_STAT, 32'h1, 32'h7, 3'h0);
			cpu.write_reg(SB + FBG_REG_IRQ_MASK, 32'h0, 4'hF, 3'h0);
			#1 chk("irq masked", 32'h0, {31'h0, irq});
			cpu.write_reg(SB + FBG_REG_IRQ_MASK, 32'h7, 4'hF, 3'h0);
			cpu.write_reg(SB + FBG_REG_IRQ_STAT, 32'h7, 4'hF, 3'h0);
			cpu.write_reg(SB + FBG_REG_STATUS, 32'h1, 4'hF, 3'h0);
			#1 chk("irq cleared", 32'h0, {31'h0, irq});
		end
		rd_exp(SB + FBG_REG_OTP, 32'h00000088, '1, 3'h0);
		// Blank only when data and check bits all read one
		frd_chk(32'hFFFFFFFF, 7'h7F, 1'b0, 1'b1);
		frd_chk(r & 32'hFFFFFFFE, 7'h15, 1'b1, 1'b1);
		frd_chk($random(seed) & 32'hFFFFFFFE, 7'h15, 1'b0, 1'b0);
		rd_exp(SB + FBG_REG_IRQ_STAT, 32'h2, 32'h2, 3'h0);
		cpu.write_reg(SB + FBG_REG_IRQ_STAT, 32'h7, 4'hF, 3'h0);
		// Self-programming id word through an open channel 5
		cpu.write_reg(SB + FBG_REG_ID_BASE + 32'h4, vec, 4'hF, 3'h0);
		rd_exp(SB + FBG_REG_ID_BASE + 32'h4, vec, '1, 3'h0);
		rd_exp(SB + FBG_REG_ID_STATUS, 32'h1, '1, 3'h0);
		// Close channel 6 on two byte lanes
		cpu.write_reg(FBG_ADDR_PROT6, 32'h0, 4'h3, 3'h0);
		rd_exp(FBG_ADDR_PROT6, 32'h066F0000, '1, 3'h0);
		rd_exp(SB + FBG_REG_VECTOR, 32'h0, '1, 3'h0);
		cpu.write_reg(SB, {8'h00, 3'h2, 13'h0, FBG_CMD_CONFIG_VEC}, 4'hF, 3'h0);
		#1 chk("guarded vector", vec, reset_vector);
		chk("guard irq", 32'h1, {31'h0, irq});
		rd_exp(FBG_ERR_BASE + FBG_ERR_ADDR_OFS, SB + FBG_REG_VECTOR, '1, 3'h0);
		rd_exp(FBG_ERR_BASE + FBG_ERR_STAT_OFS, 32'h1, '1, 3'h0);
		// Let master 1 in, shut channel 5 only
		cpu.write_reg(FBG_ADDR_PROT6, 32'h00000200, 4'h2, 3'h0);
		cpu.write_reg(FBG_ADDR_PROT5, 32'h0, 4'hF, 3'h0);
		rd_exp(SB + FBG_REG_VECTOR, vec, '1, 3'h1);
		rd_exp(SB + FBG_REG_VECTOR, 32'h0, '1, 3'h2);
		cpu.write_reg(FBG_ERR_BASE + FBG_ERR_CLR_OFS, 32'h1, 4'hF, 3'h0);
		rd_exp(SB + FBG_REG_ID_BASE, 32'h0, '1, 3'h1);
		rd_exp(FBG_ERR_BASE + FBG_ERR_ADDR_OFS, SB + FBG_REG_ID_BASE, '1, 3'h0);
		cpu.write_reg(FBG_ADDR_PROT5, FBG_PROT_RESET, 4'hF, 3'h0);
		cpu.write_reg(FBG_ADDR_PROT6, FBG_PROT_RESET, 4'hF, 3'h0);
		cpu.write_reg(SB + FBG_REG_IRQ_STAT, 32'h7, 4'hF, 3'h0);
		#1 chk("irq idle", 32'h0, {31'h0, irq});
		// Ratio set only while no operation runs
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			div_opt <= i[0];
			slow <= i[1];
			repeat (16) @(posedge clk);
			n = 0;
			repeat (64)
			begin
				@(posedge clk);
				#1 if (seq_clk === 1'b1) n++;
			end
			chk("seq ticks", (i == 0) ? 32'h10 : 32'h8, 32'(n));
		end
		// Aborted operation locks, unlocked erase clears
		@(posedge clk);
		lk_abort <= 1'b1;
		@(posedge clk);
		lk_abort <= 1'b0;
		#1 chk("lock_bit set", 32'h1, {31'h0, lock_bit});
		rd_exp(SB + FBG_REG_STATUS, 32'h4, 32'h4, 3'h0);
		@(posedge clk);
		lk_done <= 1'b1;
		@(posedge clk);
		lk_done <= 1'b0;
		#1 chk("lock_bit clear", 32'h0, {31'h0, lock_bit});
		n = 0;
		while (exp_q.size() != 0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (exp_q.size() != 0)
			chk("read queue drained", 32'h0, 32'h1);
		complete_run();
	end
endmodule // tb
